// File: core/tsr_core.sv
/*
 * Register interface of a serial temperature sensor: temperature and identity words
 * shifted out, an 8-bit mode code shifted in, over a three-wire chip-select link.
 * Assumes the link pins are asynchronous to mclk_i and the converter result arrives
 * on mclk_i with a one-cycle valid pulse.
 */
// Operation
// - Three 16-bit registers: temperature and identity read-only, mode control write-only.
// - A received code with low byte all ones selects shutdown.
// - A received code with low byte all zeros selects continuous conversion.
// - The two lowest temperature word bits always go out as ones.
// - Temperature sits in bits 15 to 2, two's complement, 0.03125 degrees each.
// - In shutdown every read returns the identity word instead of temperature.
// - Identity word holds a fixed 14-bit code above two one bits.
// - Frame is 32 clocks: 16 out from device, then 16 in from host.
// - Device changes data on falling clock, samples on rising clock.
// - Input goes through an 8-bit shift register; last eight bits act.
// - Power-up reset starts the device in continuous conversion.
`timescale 1ns/1ps
module tsr_core
	import tsr_pkg::*;
(
	input  wire logic                          mclk_i,
	input  wire logic                          rst_b_i,
	input  wire logic                          chip_sel_b_i,
	input  wire logic                          serial_bus_clock_i,
	input  wire logic                          sio_i,
	output logic                               sio_o,
	output logic                               sio_oe_o,
	input  wire logic [tsr_pkg::TSR_TEMP_W-1:0] temp_code_i,
	input  wire logic                          temp_valid_i,
	output logic                               conv_enable_o,
	output logic                               shutdown_o
);
	import tsr_pkg::*;

	logic [2:0]            pins_s;
	logic                  cs_b_s;
	logic                  sclk_s;
	logic                  sio_s;
	logic                  sclk_d_reg;
	logic                  sclk_rise;
	logic                  sclk_fall;
	logic                  cs_act;
	tsr_link_t             state_reg;
	tsr_link_t             state_next;
	tsr_mode_t             mode_reg;
	tsr_mode_t             mode_next;
	logic [TSR_TEMP_W-1:0] temp_reg;
	logic [TSR_WORD_W-1:0] tx_shift_reg;
	logic [TSR_WORD_W-1:0] tx_shift_next;
	logic [TSR_WORD_W-1:0] out_word;
	logic [TSR_RX_W-1:0]   rx_shift_reg;
	logic [TSR_RX_W-1:0]   rx_shift_next;
	logic [3:0]            rx_cnt_reg;
	logic [3:0]            rx_cnt_next;
	logic [TSR_CNT_W-1:0]  rise_cnt_reg;
	logic [TSR_CNT_W-1:0]  rise_cnt_next;
	logic                  load;
	logic                  tx_done;
	logic                  commit;

	tsr_sync #(
		.WIDTH     (3),
		.RESET_VAL (TSR_PIN_IDLE)
	) u_sync (
		.mclk_i  (mclk_i),
		.rst_b_i (rst_b_i),
		.async_i ({chip_sel_b_i, serial_bus_clock_i, sio_i}),
		.sync_o  (pins_s)
	);

	assign cs_b_s    = pins_s[2];
	assign sclk_s    = pins_s[1];
	assign sio_s     = pins_s[0];
	assign cs_act    = ~cs_b_s;
	assign sclk_rise = sclk_s & ~sclk_d_reg;
	assign sclk_fall = ~sclk_s & sclk_d_reg;

	// The read word is chosen at the start of a frame, so a conversion landing
	// mid-frame never tears the bits already on the wire.
	// The mode control word never appears here: it can be written but not read back.
	assign out_word = (mode_reg == TSR_MODE_SHUT) ? {TSR_ID_CODE, TSR_PAD_BITS}
	                                              : {temp_reg, TSR_PAD_BITS};

	assign load    = (state_reg == TSR_LINK_IDLE) && cs_act;
	assign tx_done = (state_reg == TSR_LINK_TX) && sclk_fall && (rise_cnt_reg >= TSR_TX_CLOCKS);
	// Only a frame that delivered at least eight receive bits may change the mode.
	assign commit  = (state_reg == TSR_LINK_RX) && !cs_act && (rx_cnt_reg == TSR_RX_FULL);

	always_comb begin
		case (state_reg)
			TSR_LINK_IDLE: begin
				state_next = cs_act ? TSR_LINK_TX : TSR_LINK_IDLE;
			end
			TSR_LINK_TX: begin
				if (!cs_act) begin
					state_next = TSR_LINK_IDLE;
				end else if (tx_done) begin
					state_next = TSR_LINK_RX;
				end else begin
					state_next = TSR_LINK_TX;
				end
			end
			TSR_LINK_RX: begin
				state_next = cs_act ? TSR_LINK_RX : TSR_LINK_IDLE;
			end
			default: begin
				state_next = TSR_LINK_IDLE;
			end
		endcase
	end

	assign tx_shift_next = load ? out_word
	                     : ((state_reg == TSR_LINK_TX) && sclk_fall) ? {tx_shift_reg[TSR_WORD_W-2:0], 1'b1}
	                     : tx_shift_reg;
	assign rise_cnt_next = load ? '0
	                     : (sclk_rise && (rise_cnt_reg < TSR_FRAME_CLKS)) ? rise_cnt_reg + 6'h01
	                     : rise_cnt_reg;
	assign rx_shift_next = ((state_reg == TSR_LINK_RX) && sclk_rise) ? {rx_shift_reg[TSR_RX_W-2:0], sio_s}
	                     : rx_shift_reg;
	assign rx_cnt_next   = load ? 4'h0
	                     : ((state_reg == TSR_LINK_RX) && sclk_rise && (rx_cnt_reg < TSR_RX_FULL)) ? rx_cnt_reg + 4'h1
	                     : rx_cnt_reg;

	// Codes other than the two defined ones are ignored rather than acted on.
	assign mode_next = (commit && (rx_shift_reg == TSR_CODE_SHUT)) ? TSR_MODE_SHUT
	                 : (commit && (rx_shift_reg == TSR_CODE_CONV)) ? TSR_MODE_CONV
	                 : mode_reg;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg  <= TSR_LINK_IDLE;
			sclk_d_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			sclk_d_reg <= sclk_s;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_reg <= TSR_MODE_CONV;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// Conversions are dropped in shutdown, since the converter is told to stop.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			temp_reg <= TSR_TEMP_RESET;
		end else if (temp_valid_i && (mode_reg == TSR_MODE_CONV)) begin
			temp_reg <= temp_code_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_shift_reg <= '1;
			rise_cnt_reg <= '0;
			rx_shift_reg <= '0;
			rx_cnt_reg   <= 4'h0;
		end else begin
			tx_shift_reg <= tx_shift_next;
			rise_cnt_reg <= rise_cnt_next;
			rx_shift_reg <= rx_shift_next;
			rx_cnt_reg   <= rx_cnt_next;
		end
	end

	assign sio_o         = tx_shift_reg[TSR_WORD_W-1];
	assign sio_oe_o      = (state_reg == TSR_LINK_TX);
	assign shutdown_o    = (mode_reg == TSR_MODE_SHUT);
	assign conv_enable_o = (mode_reg == TSR_MODE_CONV);

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	sequence tx_load_s;
		load;
	endsequence

	sequence rx_commit_s(logic [7:0] code);
		commit && (rx_shift_reg == code);
	endsequence

	sequence conv_load_s;
		load && (mode_reg == TSR_MODE_CONV);
	endsequence

	sequence tx_end_s;
		(state_reg == TSR_LINK_TX) && cs_act && sclk_fall && (rise_cnt_reg == TSR_TX_CLOCKS);
	endsequence

	shut_code_a: assert property (rx_commit_s(8'hFF) |=> shutdown_o && !conv_enable_o)
		else $error("Shutdown code did not enter shutdown.");
	conv_code_a: assert property (rx_commit_s(8'h00) |=> conv_enable_o && !shutdown_o)
		else $error("Zero code did not enter continuous conversion.");
	mode_hold_a: assert property (!commit |=> $stable(mode_reg))
		else $error("Mode changed without a valid code.");
	pad_ones_a: assert property (tx_load_s |=> tx_shift_reg[1:0] == 2'h3)
		else $error("Low read bits are not ones.");
	temp_word_a: assert property (conv_load_s |=> tx_shift_reg[15:2] == $past(temp_reg))
		else $error("Read word does not carry the temperature.");
	id_word_a: assert property (tx_load_s ##0 shutdown_o |=> tx_shift_reg == {14'h0A5C, 2'h3})
		else $error("Shutdown read does not carry the identity word.");
	phase_turn_a: assert property (tx_end_s |=> !sio_oe_o && (state_reg == TSR_LINK_RX))
		else $error("Data line not released after sixteen clocks.");
	out_fall_a: assert property ((state_reg == TSR_LINK_TX) && !sclk_fall |=> $stable(sio_o))
		else $error("Output bit changed away from a falling clock.");
	rx_rise_a: assert property (!((state_reg == TSR_LINK_RX) && sclk_rise) |=> $stable(rx_shift_reg))
		else $error("Receive register moved without a rising clock.");
	rx_full_a: assert property ((state_reg == TSR_LINK_RX) && !cs_act && (rx_cnt_reg < TSR_RX_FULL) |=> $stable(mode_reg))
		else $error("Mode acted on fewer than eight bits.");

endmodule // tsr_core

// File: shared/tsr_pkg.sv
/*
 * Package for the temperature sensor register interface: word layouts, mode codes,
 * the fixed identity word and the link state encoding.
 * Assumes only that tsr_core and the bench import it; tsr_sync does not.
 */
package tsr_pkg;

	localparam int          TSR_WORD_W      = 16;
	localparam int          TSR_TEMP_W      = 14;
	localparam int          TSR_RX_W        = 8;
	localparam int          TSR_CNT_W       = 6;
	localparam int          TSR_TEMP_LSB    = 2;
	localparam logic [5:0]  TSR_TX_CLOCKS   = 6'h10;
	localparam logic [5:0]  TSR_FRAME_CLKS  = 6'h20;
	localparam logic [3:0]  TSR_RX_FULL     = 4'h8;
	localparam logic [7:0]  TSR_CODE_SHUT   = 8'hFF;
	localparam logic [7:0]  TSR_CODE_CONV   = 8'h00;
	localparam logic [1:0]  TSR_PAD_BITS    = 2'h3;
	localparam logic [13:0] TSR_TEMP_RESET  = 14'h0000;
	// Idle pin levels in sync order: chip select high, serial clock low, data line high.
	localparam logic [2:0]  TSR_PIN_IDLE    = 3'h5;
	// Arbitrary maker and device code; it names no real part.
	localparam logic [13:0] TSR_ID_CODE     = 14'h0A5C;

	typedef enum logic {
		TSR_MODE_CONV = 1'b0,
		TSR_MODE_SHUT = 1'b1
	} tsr_mode_t;

	typedef enum logic [1:0] {
		TSR_LINK_IDLE = 2'b00,
		TSR_LINK_TX   = 2'b01,
		TSR_LINK_RX   = 2'b10
	} tsr_link_t;

endpackage

// File: core/tsr_sync.sv
/*
 * Two flip-flop synchroniser for a group of independent levels.
 * Assumes each bit is a slowly changing level from another clock domain.
 */
`timescale 1ns/1ps
module tsr_sync #(
	parameter int               WIDTH     = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input  wire logic             mclk_i,
	input  wire logic             rst_b_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	if (WIDTH < 1) begin : g_width_check
		$error("tsr_sync: WIDTH must be at least one");
	end

	logic [WIDTH-1:0] meta_reg;

	// Both stages reset to each line's idle level, so no false edge follows reset.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_reg <= RESET_VAL;
			sync_o   <= RESET_VAL;
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end

endmodule // tsr_sync

// File: tb/tsr_host_model.sv
/* Host controller model: drives chip select, the serial clock and its half of the data line.
 Assumes the device resolves nothing itself; the line level is worked out here. */
`timescale 1ns/1ps
module tsr_host_model (
	input  wire logic mclk_i,
	input  wire logic dev_sio_i,
	input  wire logic dev_oe_i,
	output logic      chip_sel_b_o,
	output logic      serial_bus_clock_o,
	output logic      line_o
);
	logic host_oe = 1'b0;
	logic host_d = 1'b0;
	logic idle_pat = 1'b0;
	// A line nobody drives toggles every cycle, so a stale bit cannot pass for data.
	assign line_o = dev_oe_i ? dev_sio_i : (host_oe ? host_d : idle_pat);
	always @(posedge mclk_i) idle_pat <= ~idle_pat;
	initial chip_sel_b_o = 1'b1;
	initial serial_bus_clock_o = 1'b0;
	// Clock low 20 ns, high 12 ns: the device output has settled well before each rise.
	task automatic xfer(input logic [15:0] wr, input int ntx, input int nrx, output logic [15:0] rd);
		rd = 16'h0000;
		@(posedge mclk_i);
		#1 chip_sel_b_o = 1'b0;
		#32;
		for (int i = 0; i < ntx + nrx; i++) begin
			#12;
			if (i >= ntx) begin
				host_oe = 1'b1;
				host_d = wr[nrx - 1 - (i - ntx)];
			end
			#8 if (i < ntx) rd = {rd[14:0], line_o};
			serial_bus_clock_o = 1'b1;
			#12 serial_bus_clock_o = 1'b0;
		end
		#20 host_oe = 1'b0;
		chip_sel_b_o = 1'b1;
		#40;
	endtask
endmodule // tsr_host_model

// File: tb/test_temp_sensor_register_interface.sv
/* Self-checking bench for tsr_core with a host model on the link.
 Assumes 250 MHz mclk_i and the package constants of tsr_pkg. */
`timescale 1ns/1ps
module test_temp_sensor_register_interface;
	import tsr_pkg::*;
	logic                  mclk_i, rst_b_i, temp_valid_i, cs_b, sclk, line, sio_o, sio_oe_o, conv_en, shut_o;
	logic [TSR_TEMP_W-1:0] temp_code_i, held;
	logic [15:0]           rd;
	logic                  shut;
	logic [31:0]           seed = 32'hAC79BDAC;
	int                    failures = 0;
	int                    total_checks = 0;

	tsr_core u_tsr_core (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .chip_sel_b_i(cs_b), .serial_bus_clock_i(sclk),
		.sio_i(line), .sio_o(sio_o), .sio_oe_o(sio_oe_o), .temp_code_i(temp_code_i),
		.temp_valid_i(temp_valid_i), .conv_enable_o(conv_en), .shutdown_o(shut_o));
	tsr_host_model u_tsr_host_model (.mclk_i(mclk_i), .dev_sio_i(sio_o), .dev_oe_i(sio_oe_o),
		.chip_sel_b_o(cs_b), .serial_bus_clock_o(sclk), .line_o(line));

	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [15:0] exp_word(input logic sd, input logic [TSR_TEMP_W-1:0] c);
		return sd ? {TSR_ID_CODE, TSR_PAD_BITS} : {c, TSR_PAD_BITS};
	endfunction

	task automatic chk_word(input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value read word expected %h seen %h", e, g);
		end
	endtask

	task automatic chk_flags(input logic [2:0] e, input logic [2:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value oe shutdown conv flags expected %b seen %b", e, g);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic pulse(input logic [TSR_TEMP_W-1:0] c);
		@(posedge mclk_i);
		#1 temp_code_i = c;
		temp_valid_i = 1'b1;
		@(posedge mclk_i);
		#1 temp_valid_i = 1'b0;
		if (!shut) held = c;
	endtask

	// Only a whole transmit phase followed by at least eight bits can change the mode.
	task automatic frame(input logic [15:0] wr, input int ntx, input int nrx);
		logic [15:0] w;
		w = exp_word(shut, held);
		u_tsr_host_model.xfer(wr, ntx, nrx, rd);
		chk_word(w >> (16 - ntx), rd);
		if (ntx == 16 && nrx >= 8 && wr[7:0] == TSR_CODE_SHUT) shut = 1'b1;
		if (ntx == 16 && nrx >= 8 && wr[7:0] == TSR_CODE_CONV) shut = 1'b0;
		chk_flags({1'b0, shut, ~shut}, {sio_oe_o, shut_o, conv_en});
	endtask

	initial begin
		#100000;
		failures++;
		give_verdict();
	end

	initial begin
		rst_b_i = 1'b0;
		temp_valid_i = 1'b0;
		temp_code_i = '0;
		held = TSR_TEMP_RESET;
		shut = 1'b0;
		repeat (3) @(posedge mclk_i);
		#1 rst_b_i = 1'b1;
		repeat (4) @(posedge mclk_i);
		#1;
		chk_flags(3'h1, {sio_oe_o, shut_o, conv_en});
		frame(16'h0000, 16, 16);
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			pulse(k == 0 ? 14'h2000 : (k == 1 ? 14'h1FFF : seed[13:0]));
			frame(16'h0000, 16, 16);
		end
		frame(16'hA5FF, 16, 16);
		pulse(seed[27:14]);
		frame(16'h0012, 16, 8);
		frame(16'h0000, 16, 4);
		frame(16'hFF00, 16, 16);
		frame(16'h0000, 16, 16);
		frame(16'h00FF, 5, 0);
		frame(16'h00FF, 16, 8);
		@(posedge mclk_i);
		#1 rst_b_i = 1'b0;
		repeat (3) @(posedge mclk_i);
		#1 rst_b_i = 1'b1;
		shut = 1'b0;
		held = TSR_TEMP_RESET;
		frame(16'h0000, 16, 16);
		give_verdict();
	end
endmodule // test_temp_sensor_register_interface
